// >>> dv/pwmbk_chk.sv
// Assertions on the ports of the PWM brake block
`timescale 1ns/1ps
module pwmbk_chk #(
	parameter int CW = 10,
	parameter int NCH = 4
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins
	input wire logic brake_pin,
	input wire logic [NCH-1:0] pwm_out,
	input wire logic irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [7:0] cfg_ff;
	logic run_ff;
	logic ien_ff;
	wire acc = psel && penable && pready;
	wire wr = acc && pwrite;
	wire irq_wr = wr && (paddr == 12'h3a4 || paddr == 12'h3a8);
	wire [7:0] nxt_cfg = (wr && paddr == 12'h37c) ? pwdata[7:0] : cfg_ff;
	wire nxt_run = (wr && paddr == 12'h370) ? pwdata[7] : run_ff;
	wire nxt_ien = (wr && paddr == 12'h3a8) ? pwdata[0] : ien_ff;
	// Run shadow misses hardware clears; only used in run-linked mode
	wire sw_on = cfg_ff[4] && !cfg_ff[5] && (!cfg_ff[7] || !run_ff);
	wire pin_on = cfg_ff[4] && cfg_ff[5] && !cfg_ff[7] && brake_pin == cfg_ff[6];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_ff <= 8'h00;
			run_ff <= 1'b0;
			ien_ff <= 1'b0;
		end else begin
			cfg_ff <= nxt_cfg;
			run_ff <= nxt_run;
			ien_ff <= nxt_ien;
		end
	end
	sequence s_pin_held;
		pin_on[*5];
	endsequence
	chk_ready_high: assert property (psel && penable |-> pready)
		else $error("pready low in access");
	chk_bad_addr: assert property (acc && paddr < 12'h35c |-> pslverr && (pwrite || prdata == 0))
		else $error("unmapped access not refused");
	chk_rdata_hold: assert property (!psel |=> $stable(prdata))
		else $error("prdata moved while idle");
	chk_sw_brake: assert property (sw_on[*3] |-> pwm_out == cfg_ff[3:0])
		else $error("software brake level wrong");
	chk_pin_brake: assert property (s_pin_held |-> pwm_out == cfg_ff[3:0])
		else $error("pin brake level wrong");
	chk_irq_raise: assert property (s_pin_held ##0 ien_ff |-> irq)
		else $error("irq missing on pin brake");
	chk_irq_gated: assert property (irq |-> ien_ff)
		else $error("irq while disabled");
	chk_irq_fall: assert property ($fell(irq) |-> $past(irq_wr))
		else $error("irq dropped without write");
endmodule
bind pwmbk_top pwmbk_chk #(.CW(CW), .NCH(NCH)) u_pwmbk_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .brake_pin(brake_pin),
	.pwm_out(pwm_out), .irq(irq));

// >>> dv/pwmbk_pin_model.sv
// Brake pin source standing in for the external driver
`timescale 1ns/1ps
module pwmbk_pin_model (
	// Clock and control
	input wire logic pclk,
	input wire logic trip,
	input wire logic pol,
	// Pin
	output logic brake_pin
);
	initial brake_pin = 1'b1;
	// Idles at the inactive level, never floating
	always @(posedge pclk) brake_pin <= trip ? pol : !pol;
endmodule

// >>> dv/test_pwm_brake_and_prescaler.sv
// Self-checking bench of the PWM brake block
`timescale 1ns/1ps
module test_pwm_brake_and_prescaler;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, trip = 0, pol = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic pready, pslverr, irq, brake_pin, er, p0;
	logic [3:0] pwm_out;
	int mismatches = 0, n_compared = 0, edges, highs;
	int dv[4] = '{1, 2, 4, 16};
	logic [7:0] cf[4] = '{8'haf, 8'hbf, 8'h1a, 8'h9a};
	logic [3:0] ex[4] = '{4'h4, 4'h4, 4'ha, 4'h4};
	always #5 pclk = ~pclk;
	pwmbk_pin_model u_pwmbk_pin_model (.pclk(pclk), .trip(trip), .pol(pol), .brake_pin(brake_pin));
	pwmbk_top u_pwmbk_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .brake_pin(brake_pin), .pwm_out(pwm_out), .irq(irq));
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] m, exp);
		apb(1'b0, a, 0);
		chk(nm, exp, rd & m);
	endtask
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#100us;
		mismatches++;
		give_verdict();
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rdc("flag_reg", 12'h35c, 32'hffff_ffff, 0);
		rdc("cfg_reg", 12'h37c, 32'hffff_ffff, 0);
		apb(1'b0, 12'h004, 0);
		chk("unmapped", 1, er);
		$display("test reset done");
		// Period 4 ticks: ch0 quarter duty, ch2 always high
		apb(1'b1, 12'h380, 3);
		apb(1'b1, 12'h384, 1);
		apb(1'b1, 12'h38c, 4);
		apb(1'b1, 12'h370, 32'h0000_00c0);
		repeat (1100) @(posedge pclk);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 12'h35c, i << 2);
			repeat (40) @(negedge pclk);
			edges = 0;
			highs = 0;
			p0 = pwm_out[0];
			repeat (128) begin
				@(negedge pclk);
				highs += pwm_out[0];
				edges += (pwm_out[0] !== p0);
				p0 = pwm_out[0];
			end
			chk("toggles", 64 / dv[i], edges);
			chk("high_cycles", 32, highs);
		end
		$display("test prescaler done");
		foreach (cf[i]) begin
			apb(1'b1, 12'h37c, cf[i]);
			repeat (4) @(negedge pclk);
			chk("brake_mode", ex[i], pwm_out & 4'he);
		end
		apb(1'b1, 12'h370, 0);
		repeat (4) @(negedge pclk);
		chk("run_linked", 4'ha, pwm_out);
		apb(1'b1, 12'h370, 32'h0000_0080);
		repeat (4) @(negedge pclk);
		chk("run_release", 4'h4, pwm_out & 4'he);
		$display("test brake modes done");
		for (int p = 0; p < 2; p++) begin
			apb(1'b1, 12'h37c, 0);
			pol <= p[0];
			apb(1'b1, 12'h3a8, p);
			apb(1'b1, 12'h37c, 32'h2a | (p << 6) | 32'h10);
			trip <= 1'b1;
			repeat (8) @(negedge pclk);
			chk("pin_brake", 4'ha, pwm_out);
			chk("irq_mask", p, irq);
			rdc("run_cleared", 12'h370, 32'h80, 0);
			trip <= 1'b0;
			repeat (8) @(negedge pclk);
			chk("restored", 4'h4, pwm_out & 4'he);
			rdc("flag_sticky", 12'h35c, 1, 1);
			apb(1'b1, 12'h35c, 0);
			rdc("flag_clear", 12'h35c, 1, 0);
			apb(1'b1, 12'h3a4, 1);
			@(negedge pclk);
			chk("irq_clear", 0, irq);
			apb(1'b1, 12'h370, 32'h0000_0080);
		end
		$display("test pin brake done");
		give_verdict();
	end
endmodule

// >>> rtl/pwmbk_channel.sv
// One PWM channel: compare against shared down counter
`timescale 1ns/1ps
`include "pwmbk_defines.svh"
module pwmbk_channel #(
	parameter int CW = 10
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Shared timing, own compare value and invert
	input wire logic tick,
	input wire logic [CW-1:0] count,
	input wire logic [CW-1:0] cmp,
	input wire logic invert,
	// Output
	output logic pwm_raw
);
	// Refused at elaboration: compare needs at least two count bits
	if (CW < 2) begin : g_bad_cw
		$error("pwmbk_channel: CW too small");
	end
	logic pwm_ff;
	// High for cmp counts of every period+1 counts, low for them when invert is set [RULE14]
	wire logic nxt_pwm = (count < cmp) ^ invert;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_ff <= 1'b0;
		end else if (tick) begin
			pwm_ff <= nxt_pwm;
		end
	end
	assign pwm_raw = pwm_ff;
endmodule

// >>> rtl/pwmbk_defines.svh
// Register offsets, field positions, reset values and timing counts of the PWM brake block
`ifndef PWMBK_DEFINES_SVH
`define PWMBK_DEFINES_SVH
// Printed offsets are not word multiples: they are indices, byte address is index*4
`define PWMBK_IDX_PRESCALE_FLAG 8'hd7
`define PWMBK_IDX_MAIN_CTRL 8'hdc
`define PWMBK_IDX_BRAKE_CFG 8'hdf
`define PWMBK_IDX_PERIOD 8'he0
`define PWMBK_IDX_CMP0 8'he1
`define PWMBK_IDX_IRQ_STATUS 8'he8
`define PWMBK_IDX_IRQ_CLEAR 8'he9
`define PWMBK_IDX_IRQ_ENABLE 8'hea
`define PWMBK_RST_BYTE 8'h00
`define PWMBK_RST_PERIOD 10'h3ff
`define PWMBK_RST_CMP 10'h000
// Main control fields
`define PWMBK_MC_RUN 7
`define PWMBK_MC_LOAD 6
// Brake config fields
`define PWMBK_BC_RUNLINK 7
`define PWMBK_BC_POL 6
`define PWMBK_BC_PINSEL 5
`define PWMBK_BC_EN 4
// Prescale and flag fields
`define PWMBK_PF_DIV_HI 3
`define PWMBK_PF_DIV_LO 2
`define PWMBK_PF_FLAG 0
// Prescaler terminal counts (divide minus one)
`define PWMBK_DIV1_TC 4'h0
`define PWMBK_DIV2_TC 4'h1
`define PWMBK_DIV4_TC 4'h3
`define PWMBK_DIV16_TC 4'hf
`endif

// >>> rtl/pwmbk_pkg.sv
// Types shared by the PWM brake block
package pwmbk_pkg;
	typedef struct packed {
		logic run_linked_brake_select;
		logic brake_input_polarity;
		logic pin_brake_select;
		logic brake_enable_bit;
		logic [3:0] per_channel_brake_level;
	} pwmbk_brake_cfg_t;
	typedef enum logic [1:0] {
		PWMBK_DIV1,
		PWMBK_DIV2,
		PWMBK_DIV4,
		PWMBK_DIV16
	} pwmbk_div_t;
	typedef enum {
		PWMBK_RUNNING,
		PWMBK_BRAKED
	} pwmbk_state_t;
endpackage

// >>> rtl/pwmbk_top.sv
// PWM unit with brake logic, prescaler and APB register slave
// Notes on behaviour
// [RULE1] Brake enable clear means no brake at all, whatever else is set.
// [RULE2] Enabled with both selects zero: brake held on permanently.
// [RULE3] Enabled, run-linked select only: brake while run bit is zero.
// [RULE4] Enabled, pin select only: active pin brakes, clears run, sets flag.
// [RULE5] Software must not set both selects; that pair gives no brake.
// [RULE6] Brake pin is active when its level equals the polarity bit.
// [RULE7] During brake each output takes its own brake level bit 0..3.
// [RULE8] After brake ends outputs return to their pre-brake state; code does so only for run-linked and pin brake.
// [RULE9] Brake interrupt follows the pin brake flag; code uses its own status bit, cleared via IRQ clear.
// [RULE10] Pin brake flag is sticky; only software writing zero clears it.
// [RULE11] Prescaler field picks system clock divided by 1, 2, 4 or 16.
// [RULE12] Prescaler is restarted in phase with the clock while run is set; code holds its counter at zero while run is clear.
// [RULE13] PWM period is period value plus one prescaled ticks.
// [RULE14] Each duty is its compare value over period value plus one.
`timescale 1ns/1ps
`include "pwmbk_defines.svh"
module pwmbk_top #(
	parameter int CW = 10,
	parameter int NCH = 4
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Brake pin, asynchronous
	input wire logic brake_pin,
	// PWM outputs and interrupt
	output logic [NCH-1:0] pwm_out,
	output logic irq
);
	// Refused at elaboration: register map and field layout fix both sizes
	if (CW != 10 || NCH != 4) begin : g_bad_size
		$error("pwmbk_top: only CW=10 NCH=4 supported");
	end

	// APB decode
	wire logic [7:0] idx = paddr[9:2];
	wire logic aligned = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
	wire logic acc = psel && penable;
	wire logic wr = acc && pwrite;
	wire logic is_pf = aligned && (idx == `PWMBK_IDX_PRESCALE_FLAG);
	wire logic is_mc = aligned && (idx == `PWMBK_IDX_MAIN_CTRL);
	wire logic is_bc = aligned && (idx == `PWMBK_IDX_BRAKE_CFG);
	wire logic is_per = aligned && (idx == `PWMBK_IDX_PERIOD);
	wire logic is_cmp = aligned && (idx >= `PWMBK_IDX_CMP0)
		&& (idx < `PWMBK_IDX_CMP0 + 8'(NCH));
	wire logic is_ist = aligned && (idx == `PWMBK_IDX_IRQ_STATUS);
	wire logic is_icl = aligned && (idx == `PWMBK_IDX_IRQ_CLEAR);
	wire logic is_ien = aligned && (idx == `PWMBK_IDX_IRQ_ENABLE);
	wire logic mapped = is_pf || is_mc || is_bc || is_per || is_cmp || is_ist
		|| is_icl || is_ien;
	wire logic [1:0] cmp_sel = 2'(idx - `PWMBK_IDX_CMP0);

	// Registers
	logic [7:0] mc_ff;
	pwmbk_pkg::pwmbk_brake_cfg_t bc_ff;
	logic [1:0] div_ff;
	logic flag_ff;
	logic [CW-1:0] per_ff;
	logic [CW-1:0] cmp_ff [NCH];
	logic [CW-1:0] wper_ff;
	logic [CW-1:0] wcmp_ff [NCH];
	logic ien_ff;
	logic ist_ff;
	logic [31:0] prdata_ff;
	logic pslverr_ff;

	// Brake pin synchroniser
	logic pin_s1_ff;
	logic pin_s2_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_ff <= 1'b0;
			pin_s2_ff <= 1'b0;
		end else begin
			pin_s1_ff <= brake_pin;
			pin_s2_ff <= pin_s1_ff;
		end
	end

	// Brake decode
	wire logic run = mc_ff[`PWMBK_MC_RUN];
	wire logic pin_active = (pin_s2_ff == bc_ff.brake_input_polarity); // [RULE6]
	wire logic mode_sw = !bc_ff.pin_brake_select && !bc_ff.run_linked_brake_select;
	wire logic mode_run = !bc_ff.pin_brake_select && bc_ff.run_linked_brake_select;
	wire logic mode_pin = bc_ff.pin_brake_select && !bc_ff.run_linked_brake_select;
	// Both selects set decode to no brake [RULE5]
	wire logic brake = bc_ff.brake_enable_bit && ( // [RULE1]
		mode_sw || // [RULE2]
		(mode_run && !run) || // [RULE3]
		(mode_pin && pin_active)); // [RULE4]
	wire logic pin_event = bc_ff.brake_enable_bit && mode_pin && pin_active; // [RULE4]

	// Register writes; hardware events win over software
	wire logic mc_wr = wr && is_mc;
	wire logic [7:0] mc_wval = pwdata[7:0];
	wire logic load_done;
	logic [7:0] nxt_mc;
	always_comb begin
		nxt_mc = mc_wr ? mc_wval : mc_ff;
		if (load_done) nxt_mc[`PWMBK_MC_LOAD] = 1'b0;
		if (pin_event) nxt_mc[`PWMBK_MC_RUN] = 1'b0; // [RULE4]
	end
	wire logic pf_wr = wr && is_pf;
	// Set wins; software can only clear by writing zero [RULE10]
	wire logic nxt_flag = pin_event
		|| (flag_ff && !(pf_wr && !pwdata[`PWMBK_PF_FLAG]));
	wire logic nxt_ist = pin_event || (ist_ff && !(wr && is_icl && pwdata[0]));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mc_ff <= `PWMBK_RST_BYTE;
			bc_ff <= `PWMBK_RST_BYTE;
			div_ff <= 2'b00;
			flag_ff <= 1'b0;
			ist_ff <= 1'b0;
			ien_ff <= 1'b0;
		end else begin
			mc_ff <= nxt_mc;
			flag_ff <= nxt_flag; // [RULE10]
			ist_ff <= nxt_ist;
			if (wr && is_bc) bc_ff <= pwdata[7:0];
			if (pf_wr) div_ff <= pwdata[`PWMBK_PF_DIV_HI:`PWMBK_PF_DIV_LO];
			if (wr && is_ien) ien_ff <= pwdata[0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wper_ff <= `PWMBK_RST_PERIOD;
			for (int i = 0; i < NCH; i++) wcmp_ff[i] <= `PWMBK_RST_CMP;
		end else if (wr) begin
			if (is_per) wper_ff <= pwdata[CW-1:0];
			if (is_cmp) wcmp_ff[cmp_sel] <= pwdata[CW-1:0];
		end
	end

	// Interrupt from its own status bit, set with pin brake flag, through enable [RULE9]
	assign irq = ist_ff && ien_ff;

	// Prescaler; counter reset while stopped keeps it in phase at run start
	logic [3:0] pre_ff;
	logic [3:0] tc;
	always_comb begin
		case (pwmbk_pkg::pwmbk_div_t'(div_ff)) // [RULE11]
			pwmbk_pkg::PWMBK_DIV1: tc = `PWMBK_DIV1_TC;
			pwmbk_pkg::PWMBK_DIV2: tc = `PWMBK_DIV2_TC;
			pwmbk_pkg::PWMBK_DIV4: tc = `PWMBK_DIV4_TC;
			pwmbk_pkg::PWMBK_DIV16: tc = `PWMBK_DIV16_TC;
			default: tc = `PWMBK_DIV1_TC;
		endcase
	end
	wire logic tick = run && (pre_ff >= tc);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_ff <= 4'h0;
		end else if (!run || tick) begin
			pre_ff <= 4'h0; // [RULE12]
		end else begin
			pre_ff <= pre_ff + 4'h1;
		end
	end

	// Down counter, reloads per+1 ticks per period; load on underflow
	logic [CW-1:0] cnt_ff;
	wire logic underflow = tick && (cnt_ff == '0);
	assign load_done = underflow && mc_ff[`PWMBK_MC_LOAD];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= '0;
			per_ff <= `PWMBK_RST_PERIOD;
			for (int i = 0; i < NCH; i++) cmp_ff[i] <= `PWMBK_RST_CMP;
		end else if (underflow) begin
			if (mc_ff[`PWMBK_MC_LOAD]) begin
				per_ff <= wper_ff;
				for (int i = 0; i < NCH; i++) cmp_ff[i] <= wcmp_ff[i];
				cnt_ff <= wper_ff; // [RULE13]
			end else begin
				cnt_ff <= per_ff; // [RULE13]
			end
		end else if (tick) begin
			cnt_ff <= cnt_ff - 1'b1;
		end
	end

	// Channels
	logic [NCH-1:0] raw;
	for (genvar g = 0; g < NCH; g++) begin : g_ch
		pwmbk_channel #(.CW(CW)) u_ch (
			.pclk(pclk),
			.presetn(presetn),
			.tick(tick),
			.count(cnt_ff),
			.cmp(cmp_ff[g]),
			.invert(mc_ff[g]),
			.pwm_raw(raw[g])
		);
	end

	// Brake override; channel regs freeze only while run is clear, so only run-linked and pin brake releases restore state
	logic [NCH-1:0] out_ff;
	wire logic [NCH-1:0] nxt_out = brake ? bc_ff.per_channel_brake_level : raw; // [RULE7]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_ff <= '0;
		end else begin
			out_ff <= nxt_out; // [RULE8]
		end
	end
	assign pwm_out = out_ff;

	// Read mux
	wire logic [7:0] pf_rd = {4'h0, div_ff, 1'b0, flag_ff};
	wire logic [31:0] rd_val =
		is_pf ? {24'h00_0000, pf_rd} :
		is_mc ? {24'h00_0000, mc_ff} :
		is_bc ? {24'h00_0000, bc_ff} :
		is_per ? {22'h00_0000, wper_ff} :
		is_cmp ? {22'h00_0000, wcmp_ff[cmp_sel]} :
		is_ist ? {31'h0000_0000, ist_ff} :
		is_ien ? {31'h0000_0000, ien_ff} : 32'h0000_0000;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end else if (psel && !penable) begin
			prdata_ff <= pwrite ? 32'h0000_0000 : rd_val;
			pslverr_ff <= !mapped;
		end
	end
	assign prdata = prdata_ff;
	assign pready = 1'b1;
	assign pslverr = pslverr_ff && acc;
endmodule
